// *** cdt_params.svh ***
// Constants for the CPU data transfer unit: field positions, steps, reset values.
// Assumes it is included by its bare name, before any user of the macros.
`ifndef CDT_PARAMS_SVH
`define CDT_PARAMS_SVH

// ****************************************************************
// Register specifier layout
// ****************************************************************
`define CDT_SPEC_HI_BIT   3
`define CDT_SP_IDX        3'h7

// ****************************************************************
// Stack steps and reset values
// ****************************************************************
`define CDT_STEP_WORD     32'h00000002
`define CDT_STEP_LONG     32'h00000004
`define CDT_GPR_RST       32'h00000000
`define CDT_EVEN_MASK     32'hfffffffe

`endif

// *** cdt_pkg.sv ***
// Types and helper functions of the CPU data transfer unit.
// Assumes cdt_params.svh is on the include path.
`default_nettype none
`include "cdt_params.svh"

package cdt_pkg;

  // ****************************************************************
  // Operand sizes, field lengths, operations, states
  // ****************************************************************
  typedef enum logic [1:0] {
    CDT_SZ_BYTE = 2'h0,
    CDT_SZ_WORD = 2'h1,
    CDT_SZ_LONG = 2'h2
  } cdt_size_t;

  typedef enum logic [1:0] {
    CDT_LEN_8  = 2'h0,
    CDT_LEN_16 = 2'h1,
    CDT_LEN_24 = 2'h2,
    CDT_LEN_32 = 2'h3
  } cdt_len_t;

  typedef enum logic [3:0] {
    CDT_OP_MOVE_RR    = 4'h0,
    CDT_OP_MOVE_LOAD  = 4'h1,
    CDT_OP_MOVE_STORE = 4'h2,
    CDT_OP_MOVE_IMM   = 4'h3,
    CDT_OP_POP        = 4'h4,
    CDT_OP_PUSH       = 4'h5,
    CDT_OP_RESTORE    = 4'h6,
    CDT_OP_SAVE       = 4'h7,
    CDT_OP_FROM_PSYNC = 4'h8,
    CDT_OP_TO_PSYNC   = 4'h9
  } cdt_op_t;

  // Gray order along idle, exec, mem, finish
  typedef enum logic [1:0] {
    CDT_ST_IDLE = 2'h0,
    CDT_ST_EXEC = 2'h1,
    CDT_ST_MEM  = 2'h3,
    CDT_ST_FIN  = 2'h2
  } cdt_state_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Extend an 8/16/24/32-bit field, signed for displacements
  function automatic logic [31:0] cdt_field(input logic [31:0] raw, input cdt_len_t len, input logic sgn);
    case (len)
      CDT_LEN_8:  cdt_field = {{24{sgn & raw[7]}}, raw[7:0]};
      CDT_LEN_16: cdt_field = {{16{sgn & raw[15]}}, raw[15:0]};
      CDT_LEN_24: cdt_field = {{8{sgn & raw[23]}}, raw[23:0]};
      default:    cdt_field = raw;
    endcase
  endfunction

  // Pick byte, half or whole of a 32-bit register, right justified
  function automatic logic [31:0] cdt_part(input logic [31:0] val, input logic hi, input cdt_size_t sz);
    case (sz)
      CDT_SZ_BYTE: cdt_part = hi ? {24'h000000, val[7:0]} : {24'h000000, val[15:8]};
      CDT_SZ_WORD: cdt_part = hi ? {16'h0000, val[31:16]} : {16'h0000, val[15:0]};
      default:     cdt_part = val;
    endcase
  endfunction

  // Write a part into a register, keeping the other bits
  function automatic logic [31:0] cdt_merge(input logic [31:0] old, input logic hi, input cdt_size_t sz,
                                            input logic [31:0] data);
    case (sz)
      CDT_SZ_BYTE: cdt_merge = hi ? {old[31:8], data[7:0]} : {old[31:16], data[7:0], old[7:0]};
      CDT_SZ_WORD: cdt_merge = hi ? {data[15:0], old[15:0]} : {old[31:16], data[15:0]};
      default:     cdt_merge = data;
    endcase
  endfunction

  // Stack step: two for a word, four for a longword; code 3 counts as long
  function automatic logic [31:0] cdt_step(input cdt_size_t sz);
    cdt_step = sz[1] ? `CDT_STEP_LONG : `CDT_STEP_WORD;
  endfunction

endpackage
`default_nettype wire

// *** cdt_regfile.sv ***
// General register file: eight 32-bit registers, three read ports and a stack pointer tap.
// Assumes writes are already merged to full width by the caller.
`timescale 1ns/1ns
`default_nettype none
`include "cdt_params.svh"

module cdt_regfile #(
  parameter int NREG = 8,
  parameter int IW   = 3
) (
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  input  wire logic          wr_en,
  input  wire logic [IW-1:0] wr_idx,
  input  wire logic [31:0]   wr_val,
  input  wire logic          sp_en,
  input  wire logic [31:0]   sp_val,
  input  wire logic [IW-1:0] rd_a_idx,
  input  wire logic [IW-1:0] rd_b_idx,
  input  wire logic [IW-1:0] rd_c_idx,
  output logic      [31:0]   rd_a,
  output logic      [31:0]   rd_b,
  output logic      [31:0]   rd_c,
  output logic      [31:0]   sp
);

  logic [31:0] gpr [NREG];

  // ****************************************************************
  // Read taps
  // ****************************************************************
  assign rd_a = gpr[rd_a_idx];
  assign rd_b = gpr[rd_b_idx];
  assign rd_c = gpr[rd_c_idx];
  assign sp   = gpr[`CDT_SP_IDX];

  // ****************************************************************
  // Write port; data write beats a same-cycle pointer update
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NREG; i++) begin
        gpr[i] <= `CDT_GPR_RST;
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        if (wr_en && (wr_idx == IW'(i))) begin
          gpr[i] <= wr_val;
        end else if (sp_en && (IW'(i) == `CDT_SP_IDX)) begin
          gpr[i] <= sp_val;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** cdt_xfer.sv ***
// CPU data transfer unit: moves, loads, stores, immediates, push, pop, multi save and restore.
// Assumes a memory port that answers each request with a one-cycle ack, read data right justified.
`timescale 1ns/1ns
`default_nettype none
`include "cdt_params.svh"

module cdt_xfer #(
  parameter int NREG = 8,
  parameter int IW   = 3
) (
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire logic                cmd_valid,
  input  wire cdt_pkg::cdt_op_t    cmd_op,
  input  wire cdt_pkg::cdt_size_t  cmd_size,
  input  wire logic [3:0]          cmd_rd,
  input  wire logic [3:0]          cmd_rs,
  input  wire logic [IW-1:0]       cmd_ea_reg,
  input  wire logic                cmd_ea_abs,
  input  wire logic [31:0]         cmd_disp,
  input  wire cdt_pkg::cdt_len_t   cmd_disp_len,
  input  wire logic [31:0]         cmd_imm,
  input  wire cdt_pkg::cdt_len_t   cmd_imm_len,
  input  wire logic [IW-1:0]       cmd_first,
  input  wire logic [IW-1:0]       cmd_count,
  output logic                     cmd_ready,
  output logic                     done,
  output logic                     err,
  output logic                     mem_req,
  output logic                     mem_we,
  output logic [31:0]              mem_addr,
  output cdt_pkg::cdt_size_t       mem_size,
  output logic [31:0]              mem_wdata,
  input  wire logic                mem_ack,
  input  wire logic [31:0]         mem_rdata
);

  // ****************************************************************
  // Latched command
  // ****************************************************************
  cdt_pkg::cdt_state_t state;
  cdt_pkg::cdt_state_t next_state;
  cdt_pkg::cdt_op_t    op_q;
  cdt_pkg::cdt_size_t  size_q;
  logic [3:0]          rd_q;
  logic [3:0]          rs_q;
  logic [IW-1:0]       ea_q;
  logic                abs_q;
  logic [31:0]         disp_q;
  logic [31:0]         imm_q;
  logic [IW-1:0]       cur_q;
  logic [IW-1:0]       left_q;
  logic                bad_q;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire accept   = cmd_valid && cmd_ready;
  wire cmd_bad  = (cmd_op > cdt_pkg::CDT_OP_SAVE);
  wire is_multi = (op_q == cdt_pkg::CDT_OP_RESTORE) || (op_q == cdt_pkg::CDT_OP_SAVE);
  wire is_dec   = (op_q == cdt_pkg::CDT_OP_PUSH) || (op_q == cdt_pkg::CDT_OP_SAVE);
  wire is_inc   = (op_q == cdt_pkg::CDT_OP_POP) || (op_q == cdt_pkg::CDT_OP_RESTORE);
  wire is_load  = is_inc || (op_q == cdt_pkg::CDT_OP_MOVE_LOAD);
  wire is_mem   = is_load || is_dec || (op_q == cdt_pkg::CDT_OP_MOVE_STORE);
  wire is_rr    = (op_q == cdt_pkg::CDT_OP_MOVE_RR);
  wire is_imm   = (op_q == cdt_pkg::CDT_OP_MOVE_IMM);
  wire more     = is_multi && (left_q > IW'(1));
  wire ack_now  = (state == cdt_pkg::CDT_ST_MEM) && mem_ack;

  // Multi forms are longword only; byte stack ops are widened to word
  wire cdt_pkg::cdt_size_t eff_size = is_multi ? cdt_pkg::CDT_SZ_LONG :
                                      ((is_inc || is_dec) && (size_q == cdt_pkg::CDT_SZ_BYTE)) ?
                                      cdt_pkg::CDT_SZ_WORD : size_q;

  // Register halves chosen by the top bit of a specifier
  wire          src_hi = is_multi ? 1'b0 : rs_q[`CDT_SPEC_HI_BIT];
  wire          dst_hi = is_multi ? 1'b0 : rd_q[`CDT_SPEC_HI_BIT];
  wire [IW-1:0] src_ix = is_multi ? cur_q : rs_q[IW-1:0];
  wire [IW-1:0] dst_ix = is_multi ? cur_q : rd_q[IW-1:0];

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic        wr_en;
  logic [31:0] wr_val;
  logic        sp_en;
  logic [31:0] sp_val;
  logic [31:0] rf_src;
  logic [31:0] rf_base;
  logic [31:0] rf_dst;
  logic [31:0] sp;

  cdt_regfile #(
    .NREG (NREG),
    .IW   (IW)
  ) u_regfile (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .wr_en    (wr_en),
    .wr_idx   (dst_ix),
    .wr_val   (wr_val),
    .sp_en    (sp_en),
    .sp_val   (sp_val),
    .rd_a_idx (src_ix),
    .rd_b_idx (ea_q),
    .rd_c_idx (dst_ix),
    .rd_a     (rf_src),
    .rd_b     (rf_base),
    .rd_c     (rf_dst),
    .sp       (sp)
  );

  // ****************************************************************
  // Addresses and stack pointer arithmetic
  // ****************************************************************
  wire [31:0] step    = cdt_pkg::cdt_step(eff_size);
  wire [31:0] sp_dec  = sp - step;
  wire [31:0] sp_inc  = sp + step;
  wire [31:0] ea_move = abs_q ? disp_q : (rf_base + disp_q);
  wire [31:0] raw_ea  = is_dec ? sp_dec : (is_inc ? sp : ea_move);
  // No address error exists, so odd word accesses just drop bit zero
  wire [31:0] mem_ea  = (eff_size == cdt_pkg::CDT_SZ_BYTE) ? raw_ea : (raw_ea & `CDT_EVEN_MASK);

  // ****************************************************************
  // Write-back selection
  // ****************************************************************
  wire [31:0] src_part = cdt_pkg::cdt_part(rf_src, src_hi, eff_size);
  wire [31:0] src_val  = is_imm ? imm_q : src_part;
  wire [31:0] wb_data  = (state == cdt_pkg::CDT_ST_MEM) ? mem_rdata : src_val;

  assign wr_en  = ((state == cdt_pkg::CDT_ST_EXEC) && (is_rr || is_imm)) ||
                  (ack_now && is_load);
  assign wr_val = cdt_pkg::cdt_merge(rf_dst, dst_hi, eff_size, wb_data);
  // Pre-decrement when the request goes out, post-increment when the data returns
  assign sp_en  = ((state == cdt_pkg::CDT_ST_EXEC) && is_dec) || (ack_now && is_inc);
  assign sp_val = is_dec ? sp_dec : sp_inc;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      cdt_pkg::CDT_ST_IDLE: begin
        if (accept) begin
          next_state = cmd_bad ? cdt_pkg::CDT_ST_FIN : cdt_pkg::CDT_ST_EXEC;
        end
      end
      cdt_pkg::CDT_ST_EXEC: begin
        next_state = is_mem ? cdt_pkg::CDT_ST_MEM : cdt_pkg::CDT_ST_FIN;
      end
      cdt_pkg::CDT_ST_MEM: begin
        if (mem_ack) begin
          next_state = more ? cdt_pkg::CDT_ST_EXEC : cdt_pkg::CDT_ST_FIN;
        end
      end
      cdt_pkg::CDT_ST_FIN: begin
        next_state = cdt_pkg::CDT_ST_IDLE;
      end
      default: begin
        next_state = cdt_pkg::CDT_ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Command capture; fields extended once here
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_q   <= cdt_pkg::CDT_OP_MOVE_RR;
      size_q <= cdt_pkg::CDT_SZ_BYTE;
      rd_q   <= 4'h0;
      rs_q   <= 4'h0;
      ea_q   <= '0;
      abs_q  <= 1'b0;
      disp_q <= 32'h00000000;
      imm_q  <= 32'h00000000;
      bad_q  <= 1'b0;
    end else if (accept) begin
      op_q   <= cmd_op;
      size_q <= cmd_size;
      rd_q   <= cmd_rd;
      rs_q   <= cmd_rs;
      ea_q   <= cmd_ea_reg;
      abs_q  <= cmd_ea_abs;
      disp_q <= cdt_pkg::cdt_field(cmd_disp, cmd_disp_len, 1'b1);
      imm_q  <= cdt_pkg::cdt_field(cmd_imm, cmd_imm_len, 1'b0);
      bad_q  <= cmd_bad;
    end
  end

  // List walk: save goes upward, restore comes back downward
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cur_q  <= '0;
      left_q <= '0;
    end else if (accept) begin
      cur_q  <= (cmd_op == cdt_pkg::CDT_OP_RESTORE) ? IW'(cmd_first + cmd_count - IW'(1)) : cmd_first;
      left_q <= cmd_count;
    end else if (ack_now && more) begin
      cur_q  <= (op_q == cdt_pkg::CDT_OP_SAVE) ? IW'(cur_q + IW'(1)) : IW'(cur_q - IW'(1));
      left_q <= IW'(left_q - IW'(1));
    end
  end

  // ****************************************************************
  // State, handshake and memory port registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state     <= cdt_pkg::CDT_ST_IDLE;
      cmd_ready <= 1'b0;
      done      <= 1'b0;
      err       <= 1'b0;
    end else begin
      state     <= next_state;
      cmd_ready <= (next_state == cdt_pkg::CDT_ST_IDLE);
      done      <= (state == cdt_pkg::CDT_ST_FIN);
      err       <= (state == cdt_pkg::CDT_ST_FIN) && bad_q;
    end
  end

  // Request stays up until the ack; address and data frozen meanwhile
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 32'h00000000;
      mem_size  <= cdt_pkg::CDT_SZ_BYTE;
      mem_wdata <= 32'h00000000;
    end else if ((state == cdt_pkg::CDT_ST_EXEC) && is_mem) begin
      mem_req   <= 1'b1;
      mem_we    <= !is_load;
      mem_addr  <= mem_ea;
      mem_size  <= eff_size;
      mem_wdata <= src_part;
    end else if (ack_now) begin
      mem_req   <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** cdt_xfer_props.sv ***
// Port checker for the CPU data transfer unit.
// Assumes it is bound to every cdt_xfer instance and shares its clock and reset.
`timescale 1ns/1ns
`default_nettype none
module cdt_xfer_props (
  input wire logic               clk_sys,
  input wire logic               arst_n,
  input wire logic               cmd_valid,
  input wire cdt_pkg::cdt_op_t   cmd_op,
  input wire logic               cmd_ready,
  input wire logic               done,
  input wire logic               err,
  input wire logic               mem_req,
  input wire logic               mem_we,
  input wire logic [31:0]        mem_addr,
  input wire cdt_pkg::cdt_size_t mem_size,
  input wire logic [31:0]        mem_wdata,
  input wire logic               mem_ack
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Accepted command; opcodes from eight up are refused
  wire take = cmd_valid && cmd_ready;

  // ****************
  // Command timing
  // ****************
  a_done_pulse: assert property (done |=> !done) else $error("done held longer than one cycle");
  a_err_done: assert property (err |-> done) else $error("err without done");
  a_refuse_time: assert property (take && cmd_op[3] |-> ##2 (done && err))
    else $error("refused command did not end with err");
  a_refuse_quiet: assert property (take && cmd_op[3] |-> !mem_req [*3])
    else $error("refused command touched memory");
  a_move_latency: assert property (take && cmd_op == cdt_pkg::CDT_OP_MOVE_RR
    |=> !done [*2] ##1 (done && !err)) else $error("register move finished at the wrong cycle");

  // ****************
  // Memory side
  // ****************
  a_even_addr: assert property (mem_req && mem_size != cdt_pkg::CDT_SZ_BYTE |-> !mem_addr[0])
    else $error("odd address on word or longword access");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
    && $stable(mem_wdata)) else $error("request changed before ack");
  a_req_drop: assert property (mem_req && mem_ack |=> !mem_req) else $error("request kept after ack");
  a_push_write: assert property (take && cmd_op == cdt_pkg::CDT_OP_PUSH |-> ##2 (mem_req && mem_we
    && mem_size != cdt_pkg::CDT_SZ_BYTE)) else $error("push did not start a word or long write");
  a_pop_read: assert property (take && cmd_op == cdt_pkg::CDT_OP_POP |-> ##2 (mem_req && !mem_we
    && mem_size != cdt_pkg::CDT_SZ_BYTE)) else $error("pop did not start a word or long read");
  a_save_long: assert property (take && cmd_op == cdt_pkg::CDT_OP_SAVE |-> ##2 (mem_req && mem_we
    && mem_size == cdt_pkg::CDT_SZ_LONG)) else $error("multi save not a longword write");
  a_restore_long: assert property (take && cmd_op == cdt_pkg::CDT_OP_RESTORE |-> ##2 (mem_req
    && !mem_we && mem_size == cdt_pkg::CDT_SZ_LONG)) else $error("multi restore not a longword read");
  // Main scenarios reached
  c_refused: cover property (take && cmd_op[3]);
  c_save: cover property (take && cmd_op == cdt_pkg::CDT_OP_SAVE);
  c_write_ack: cover property (mem_req && mem_ack && mem_we);
endmodule

bind cdt_xfer cdt_xfer_props u_cdt_xfer_props (.clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_ready(cmd_ready), .done(done), .err(err), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack));
`default_nettype wire

// *** cdt_mem_model.sv ***
// Behavioural memory on the far side of the transfer unit's memory port.
// Assumes one request at a time, held until the edge after its ack.
`timescale 1ns/1ns
`default_nettype none
module cdt_mem_model (
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  input  wire logic               slow,
  input  wire logic               mem_req,
  input  wire logic               mem_we,
  input  wire logic [31:0]        mem_addr,
  input  wire cdt_pkg::cdt_size_t mem_size,
  input  wire logic [31:0]        mem_wdata,
  output logic                    mem_ack,
  output logic [31:0]             mem_rdata
);
  logic [31:0] cells [logic [31:0]];
  logic [1:0]  wait_cnt;
  logic [31:0] keep_mask;

  // Narrow writes keep only their bits, so narrow reads return right justified
  assign keep_mask = (mem_size == cdt_pkg::CDT_SZ_BYTE) ? 32'h000000ff :
                     (mem_size == cdt_pkg::CDT_SZ_WORD) ? 32'h0000ffff : 32'hffffffff;

  // Ack at once or after three waits; outside an ack the data lines toggle
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h5a5a5a5a;
      wait_cnt  <= 2'h0;
    end else if (mem_req && !mem_ack && (!slow || wait_cnt == 2'h3)) begin
      mem_ack  <= 1'b1;
      wait_cnt <= 2'h0;
      if (mem_we) begin
        cells[mem_addr] = mem_wdata & keep_mask;
      end
      mem_rdata <= mem_we ? ~mem_rdata : (cells.exists(mem_addr) ? cells[mem_addr] : 32'h0);
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the CPU data transfer unit, registers seen through stores.
// Assumes the behavioural memory model and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic               clk_sys, arst_n, cmd_valid, cmd_ea_abs, slow, cmd_ready, done, err;
  logic               mem_req, mem_we, mem_ack;
  cdt_pkg::cdt_op_t   cmd_op;
  cdt_pkg::cdt_size_t cmd_size, mem_size;
  cdt_pkg::cdt_len_t  cmd_len;
  logic [3:0]         cmd_rd, cmd_rs;
  logic [2:0]         cmd_ea_reg, cmd_count;
  logic [31:0]        cmd_val, mem_addr, mem_wdata, mem_rdata, seed;
  logic [31:0]        q_addr[$], q_data[$];
  int                 error_cnt, tests_run;

  cdt_xfer u_cdt_xfer (.clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_size(cmd_size), .cmd_rd(cmd_rd), .cmd_rs(cmd_rs), .cmd_ea_reg(cmd_ea_reg), .cmd_ea_abs(cmd_ea_abs),
    .cmd_disp(cmd_val), .cmd_disp_len(cmd_len), .cmd_imm(cmd_val), .cmd_imm_len(cmd_len),
    .cmd_first(cmd_rd[2:0]), .cmd_count(cmd_count), .cmd_ready(cmd_ready), .done(done), .err(err),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  cdt_mem_model u_cdt_mem_model (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  // ****************
  // Bench helpers
  // ****************
  // Reads and writes logged once, at the edge that closes each ack cycle, written or read data alike
  always @(posedge clk_sys) begin
    if (mem_req && mem_ack) begin
      q_addr.push_back(mem_addr);
      q_data.push_back(mem_we ? mem_wdata : mem_rdata);
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Part of a register named by a specifier, right justified
  function automatic logic [31:0] sel(input logic [31:0] v, input logic [3:0] s, input logic [1:0] sz);
    return sz == 2'h0 ? (s[3] ? {24'h0, v[7:0]} : {24'h0, v[15:8]})
         : sz == 2'h1 ? (s[3] ? {16'h0, v[31:16]} : {16'h0, v[15:0]}) : v;
  endfunction
  function automatic logic [31:0] put(input logic [31:0] o, input logic [3:0] s, input logic [1:0] sz,
                                      input logic [31:0] d);
    return sz == 2'h0 ? (s[3] ? {o[31:8], d[7:0]} : {o[31:16], d[7:0], o[7:0]})
         : sz == 2'h1 ? (s[3] ? {d[15:0], o[15:0]} : {o[31:16], d[15:0]}) : d;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One command: held until taken, then bounded wait for done
  task automatic issue(input logic [3:0] op, input logic [1:0] sz = 2'h2, input logic [3:0] rd = 4'h0,
    input logic [3:0] rs = 4'h0, input logic [31:0] v = 32'h0, input logic [1:0] ln = 2'h3,
    input logic [2:0] ea = 3'h0, input logic ab = 1'b1, input logic [2:0] cnt = 3'h0);
    int n;
    q_addr.delete();
    q_data.delete();
    @(posedge clk_sys);
    cmd_valid  <= 1'b1;
    cmd_op     <= cdt_pkg::cdt_op_t'(op);
    cmd_size   <= cdt_pkg::cdt_size_t'(sz);
    cmd_rd     <= rd;
    cmd_rs     <= rs;
    cmd_val    <= v;
    cmd_len    <= cdt_pkg::cdt_len_t'(ln);
    cmd_ea_reg <= ea;
    cmd_ea_abs <= ab;
    cmd_count  <= cnt;
    slow       <= seed[4];
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (done !== 1'b1 && n < 300);
    check("done", {31'h0, done}, 32'h1);
    check("err", {31'h0, err}, {31'h0, op[3]});
  endtask
  task automatic set_reg(input logic [2:0] r, input logic [31:0] v);
    issue(4'h3, 2'h2, {1'b0, r}, 4'h0, v);
  endtask
  // Register contents shown by a longword store to a scratch address
  task automatic chk_reg(input string what, input logic [2:0] r, input logic [31:0] exp);
    issue(4'h2, 2'h2, 4'h0, {1'b0, r}, 32'h80);
    check(what, q_data[0], exp);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************
  // Clock, watchdog, tests
  // ****************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Whole run needs several hundred cycles; hang cut well beyond that
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("Error watchdog expected done seen timeout");
    results();
  end
  initial begin
    logic [31:0] a, b, vals[4];
    logic [3:0]  d;
    int          k, h;
    {arst_n, cmd_valid, cmd_ea_abs, slow, cmd_rd, cmd_rs, cmd_ea_reg, cmd_count, cmd_val} = '0;
    cmd_op = cdt_pkg::CDT_OP_MOVE_RR;
    cmd_size = cdt_pkg::CDT_SZ_LONG;
    cmd_len = cdt_pkg::CDT_LEN_32;
    seed = 32'h20;
    error_cnt = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_sys);
    check("ready in reset", {31'h0, cmd_ready}, 32'h0);
    arst_n <= 1'b1;
    chk_reg("reg6 reset", 3'h6, 32'h0);
    // Immediates of every field length, then moves of every size and half
    for (k = 0; k < 4; k++) begin
      a = rnd();
      issue(4'h3, 2'h2, 4'h1, 4'h0, a, k[1:0]);
      chk_reg("imm len", 3'h1, a & (32'hffffffff >> (8 * (3 - k))));
    end
    for (k = 0; k < 6; k++) begin
      a = rnd();
      b = rnd();
      d = {k[0], 3'h3};
      set_reg(3'h2, a);
      set_reg(3'h3, b);
      set_reg(3'h4, b);
      issue(4'h0, k[2:1], d, {a[0], 3'h2});
      issue(4'h3, k[2:1], {k[0], 3'h4}, 4'h0, a);
      chk_reg("move reg", 3'h3, put(b, d, k[2:1], sel(a, {a[0], 3'h2}, k[2:1])));
      chk_reg("move imm", 3'h4, put(b, {k[0], 3'h4}, k[2:1], a));
    end
    $display("test moves done");
    // Stores and loads, odd addresses folded down for word
    a = rnd();
    b = rnd();
    set_reg(3'h1, a);
    set_reg(3'h5, 32'h203);
    set_reg(3'h6, b);
    issue(4'h2, 2'h2, 4'h0, 4'h1, 32'h200);
    check("store long addr", q_addr[0], 32'h200);
    issue(4'h1, 2'h1, 4'h6, 4'h0, 32'hfe, 2'h0, 3'h5, 1'b0);
    check("load odd addr", q_addr[0], 32'h200);
    chk_reg("load word", 3'h6, put(b, 4'h6, 2'h1, a));
    issue(4'h2, 2'h1, 4'h0, 4'h9, 32'h301);
    check("store odd addr", q_addr[0], 32'h300);
    check("store word data", q_data[0], {16'h0, a[31:16]});
    issue(4'h2, 2'h0, 4'h0, 4'h9, 32'h305);
    check("store byte addr", q_addr[0], 32'h305);
    check("store byte data", q_data[0], {24'h0, a[7:0]});
    $display("test memory done");
    // Push and pop in word and longword, pointer back where it began
    set_reg(3'h7, 32'h400);
    set_reg(3'h2, b);
    issue(4'h5, 2'h2, 4'h0, 4'h1);
    check("push long", q_addr[0], 32'h3fc);
    issue(4'h5, 2'h1, 4'h0, 4'h2);
    check("push word", q_addr[0], 32'h3fa);
    check("push data", q_data[0], {16'h0, b[15:0]});
    set_reg(3'h3, a);
    issue(4'h4, 2'h1, 4'h3);
    check("pop word", q_addr[0], 32'h3fa);
    issue(4'h4, 2'h2, 4'h4);
    check("pop long", q_addr[0], 32'h3fc);
    chk_reg("pop word data", 3'h3, put(a, 4'h3, 2'h1, {16'h0, b[15:0]}));
    chk_reg("pop long data", 3'h4, a);
    chk_reg("stack pointer", 3'h7, 32'h400);
    $display("test stack done");
    // Multi save of four registers, clobber, restore
    set_reg(3'h7, 32'h500);
    for (k = 0; k < 4; k++) begin
      vals[k] = rnd();
      set_reg(k[2:0], vals[k]);
    end
    issue(4'h7, 2'h2, 4'h0, 4'h0, 32'h0, 2'h3, 3'h0, 1'b1, 3'h4);
    for (k = 0; k < 4; k++) begin
      check("save addr", q_addr[k], 32'h4fc - 4 * k);
      check("save data", q_data[k], vals[k]);
    end
    for (k = 0; k < 4; k++) begin
      set_reg(k[2:0], 32'h0);
    end
    issue(4'h6, 2'h2, 4'h0, 4'h0, 32'h0, 2'h3, 3'h0, 1'b1, 3'h4);
    for (k = 0; k < 4; k++) begin
      check("restore addr", q_addr[k], 32'h4f0 + 4 * k);
    end
    for (k = 0; k < 4; k++) begin
      chk_reg("restore data", k[2:0], vals[k]);
    end
    chk_reg("pointer after list", 3'h7, 32'h500);
    $display("test multi done");
    // Every refused opcode: no memory traffic, register 1 untouched
    for (h = 8; h < 16; h++) begin
      issue(h[3:0], 2'h2, 4'h1, 4'h2, rnd());
      check("refused traffic", q_addr.size(), 32'h0);
    end
    chk_reg("after refused", 3'h1, vals[1]);
    $display("test refused done");
    results();
  end
endmodule
`default_nettype wire
